// >>> hdl/occ_opcode_cycle_decoder.sv
`timescale 1ns/100ps
module occ_opcode_cycle_decoder (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  // Opcode from fetch path
  input  wire logic              opValid,
  output logic                   opReady,
  input  wire logic [7:0]        opByte,
  // Decode towards sequencer
  output logic                   decValid,
  output occ_pkg::occ_dec_t      decInfo,
  // Run-time facts from sequencer
  input  wire logic              resValid,
  output logic                   resReady,
  input  wire occ_pkg::occ_res_t resInfo,
  // Final cycle figure
  output logic                   doneValid,
  output logic                   doneTaken,
  output occ_pkg::occ_cyc_t      doneCycles
);

  logic                rstSync_n;
  occ_pkg::occ_state_t state_q;
  occ_pkg::occ_state_t state_d;
  occ_pkg::occ_cyc_t   sum;
  occ_pkg::occ_dec_t   newDec;
  logic                newTaken;

  occ_reset_sync uSync (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .rstSync_n (rstSync_n)
  );

  // Instruction length follows the addressing mode
  function automatic occ_pkg::occ_len_t lenOf(occ_pkg::occ_mode_t m);
    occ_pkg::occ_len_t l;
    case (m)
      occ_pkg::MODE_IMPLIED, occ_pkg::MODE_ACCUM: l = occ_pkg::LEN_ONE;
      occ_pkg::MODE_ABS, occ_pkg::MODE_ABS_X, occ_pkg::MODE_ABS_Y,
      occ_pkg::MODE_INDIRECT: l = occ_pkg::LEN_THREE;
      default: l = occ_pkg::LEN_TWO;
    endcase
    return l;
  endfunction

  function automatic occ_pkg::occ_dec_t mk(
    occ_pkg::occ_op_t   op,
    occ_pkg::occ_mode_t mode,
    occ_pkg::occ_base_t cyc,
    logic               pen
  );
    occ_pkg::occ_dec_t d;
    d.op          = op;
    d.mode        = mode;
    d.len         = lenOf(mode);
    d.cycles      = cyc;
    d.pagePenalty = pen;
    d.isBranch    = (mode == occ_pkg::MODE_REL);
    d.bitSel      = 3'd0;
    return d;
  endfunction

  // Accumulator group, columns 1, 5, 9 and D
  function automatic occ_pkg::occ_op_t aluOp(logic [2:0] g);
    occ_pkg::occ_op_t o;
    case (g)
      3'd0:    o = occ_pkg::OP_OR;
      3'd1:    o = occ_pkg::OP_AND;
      3'd2:    o = occ_pkg::OP_XOR;
      3'd3:    o = occ_pkg::OP_ADD;
      3'd4:    o = occ_pkg::OP_STORE_A;
      3'd5:    o = occ_pkg::OP_LDA;
      3'd6:    o = occ_pkg::OP_CMP;
      default: o = occ_pkg::OP_SUB;
    endcase
    return o;
  endfunction

  // Shift, X-register, INC and DEC group, columns 6, A and E
  function automatic occ_pkg::occ_op_t rmwOp(logic [2:0] g);
    occ_pkg::occ_op_t o;
    case (g)
      3'd0:    o = occ_pkg::OP_SHL;
      3'd1:    o = occ_pkg::OP_ROL;
      3'd2:    o = occ_pkg::OP_SHR;
      3'd3:    o = occ_pkg::OP_ROR;
      3'd4:    o = occ_pkg::OP_STORE_X;
      3'd5:    o = occ_pkg::OP_LOAD_X;
      3'd6:    o = occ_pkg::OP_DEC;
      default: o = occ_pkg::OP_INC;
    endcase
    return o;
  endfunction

  // Column 8: stack, flag and Y-register operations, plus INX
  function automatic occ_pkg::occ_dec_t col8(logic [3:0] r);
    occ_pkg::occ_dec_t d;
    occ_pkg::occ_op_t  o;
    occ_pkg::occ_base_t c;
    c = occ_pkg::CYC_IMPLIED;
    case (r)
      4'h0:    o = occ_pkg::OP_PUSH_S;
      4'h2:    o = occ_pkg::OP_PULL_S;
      4'h4:    o = occ_pkg::OP_PUSH_A;
      4'h6:    o = occ_pkg::OP_PULL_A;
      4'h1:    o = occ_pkg::OP_CLC;
      4'h3:    o = occ_pkg::OP_SEC;
      4'h5:    o = occ_pkg::OP_CLI;
      4'h7:    o = occ_pkg::OP_SEI;
      4'h8:    o = occ_pkg::OP_DEY;
      4'h9:    o = occ_pkg::OP_TYA;
      4'hA:    o = occ_pkg::OP_TAY;
      4'hB:    o = occ_pkg::OP_CLV;
      4'hC:    o = occ_pkg::OP_INY;
      4'hD:    o = occ_pkg::OP_CLD;
      4'hE:    o = occ_pkg::OP_INX;
      default: o = occ_pkg::OP_SED;
    endcase
    if (!r[3] && !r[0]) begin
      c = r[1] ? occ_pkg::CYC_PULL : occ_pkg::CYC_PUSH;
    end
    d = mk(o, occ_pkg::MODE_IMPLIED, c, 1'b0);
    return d;
  endfunction

  // Whole matrix: row is the high nibble, column the low nibble
  function automatic occ_pkg::occ_dec_t decode(logic [7:0] opc);
    occ_pkg::occ_dec_t d;
    logic [3:0] r;
    logic [3:0] c;
    logic       st;
    logic       xy;
    r  = opc[7:4];
    c  = opc[3:0];
    st = (r[3:1] == 3'd4);
    xy = (r[3:2] == 2'b10);
    d  = mk(occ_pkg::OP_UNDEF, occ_pkg::MODE_IMPLIED, occ_pkg::CYC_IMPLIED, 1'b0);
    case (c)
      4'h0: begin
        if (r[0]) begin
          d        = mk(occ_pkg::OP_BRANCH, occ_pkg::MODE_REL, occ_pkg::CYC_REL, 1'b0);
          d.bitSel = r[3:1];
        end else begin
          case (r[3:1])
            3'd0: d = mk(occ_pkg::OP_BREAK, occ_pkg::MODE_IMPLIED, occ_pkg::CYC_BREAK, 1'b0);
            3'd1: d = mk(occ_pkg::OP_CALL, occ_pkg::MODE_ABS, occ_pkg::CYC_CALL, 1'b0);
            3'd2: d = mk(occ_pkg::OP_IRET, occ_pkg::MODE_IMPLIED, occ_pkg::CYC_RETURN, 1'b0);
            3'd3: d = mk(occ_pkg::OP_RETURN, occ_pkg::MODE_IMPLIED, occ_pkg::CYC_RETURN, 1'b0);
            3'd5: d = mk(occ_pkg::OP_LDY, occ_pkg::MODE_IMM, occ_pkg::CYC_IMM, 1'b0);
            3'd6: d = mk(occ_pkg::OP_CPY, occ_pkg::MODE_IMM, occ_pkg::CYC_IMM, 1'b0);
            3'd7: d = mk(occ_pkg::OP_CPX, occ_pkg::MODE_IMM, occ_pkg::CYC_IMM, 1'b0);
            default: ;
          endcase
        end
      end
      4'h1: begin
        if (!r[0]) begin
          d = mk(aluOp(r[3:1]), occ_pkg::MODE_IND_X, occ_pkg::CYC_IND_X, 1'b0);
        end else if (st) begin
          d = mk(occ_pkg::OP_STORE_A, occ_pkg::MODE_IND_Y, occ_pkg::CYC_STORE_IND_Y, 1'b0);
        end else begin
          d = mk(aluOp(r[3:1]), occ_pkg::MODE_IND_Y, occ_pkg::CYC_IND_Y, 1'b1);
        end
      end
      4'h2: begin
        if (r == 4'hA) begin
          d = mk(occ_pkg::OP_LOAD_X, occ_pkg::MODE_IMM, occ_pkg::CYC_IMM, 1'b0);
        end
      end
      4'h4: begin
        case (r)
          4'h2: d = mk(occ_pkg::OP_TEST, occ_pkg::MODE_ZERO_PAGE, occ_pkg::CYC_ZERO, 1'b0);
          4'h8: d = mk(occ_pkg::OP_STY, occ_pkg::MODE_ZERO_PAGE, occ_pkg::CYC_ZERO, 1'b0);
          4'h9: d = mk(occ_pkg::OP_STY, occ_pkg::MODE_ZERO_X, occ_pkg::CYC_ZERO_IDX, 1'b0);
          4'hA: d = mk(occ_pkg::OP_LDY, occ_pkg::MODE_ZERO_PAGE, occ_pkg::CYC_ZERO, 1'b0);
          4'hB: d = mk(occ_pkg::OP_LDY, occ_pkg::MODE_ZERO_X, occ_pkg::CYC_ZERO_IDX, 1'b0);
          4'hC: d = mk(occ_pkg::OP_CPY, occ_pkg::MODE_ZERO_PAGE, occ_pkg::CYC_ZERO, 1'b0);
          4'hE: d = mk(occ_pkg::OP_CPX, occ_pkg::MODE_ZERO_PAGE, occ_pkg::CYC_ZERO, 1'b0);
          default: ;
        endcase
      end
      4'h5: begin
        if (r[0]) begin
          d = mk(aluOp(r[3:1]), occ_pkg::MODE_ZERO_X, occ_pkg::CYC_ZERO_IDX, 1'b0);
        end else begin
          d = mk(aluOp(r[3:1]), occ_pkg::MODE_ZERO_PAGE, occ_pkg::CYC_ZERO, 1'b0);
        end
      end
      4'h6: begin
        if (xy && r[0]) begin
          d = mk(rmwOp(r[3:1]), occ_pkg::MODE_ZERO_Y, occ_pkg::CYC_ZERO_IDX, 1'b0);
        end else if (xy) begin
          d = mk(rmwOp(r[3:1]), occ_pkg::MODE_ZERO_PAGE, occ_pkg::CYC_ZERO, 1'b0);
        end else if (r[0]) begin
          d = mk(rmwOp(r[3:1]), occ_pkg::MODE_ZERO_X, occ_pkg::CYC_RMW_ZERO_IDX, 1'b0);
        end else begin
          d = mk(rmwOp(r[3:1]), occ_pkg::MODE_ZERO_PAGE, occ_pkg::CYC_RMW_ZERO, 1'b0);
        end
      end
      4'h7: begin
        d = mk(r[3] ? occ_pkg::OP_SET_BIT : occ_pkg::OP_CLR_BIT, occ_pkg::MODE_ZERO_PAGE,
               occ_pkg::CYC_BIT_RMW, 1'b0);
        d.bitSel = r[2:0];
      end
      4'h8: begin
        d = col8(r);
      end
      4'h9: begin
        if (r[0] && st) begin
          d = mk(occ_pkg::OP_STORE_A, occ_pkg::MODE_ABS_Y, occ_pkg::CYC_STORE_ABSIDX, 1'b0);
        end else if (r[0]) begin
          d = mk(aluOp(r[3:1]), occ_pkg::MODE_ABS_Y, occ_pkg::CYC_ABS_IDX, 1'b1);
        end else if (!st) begin
          d = mk(aluOp(r[3:1]), occ_pkg::MODE_IMM, occ_pkg::CYC_IMM, 1'b0);
        end
      end
      4'hA: begin
        case (r)
          4'h0, 4'h2, 4'h4, 4'h6: begin
            d = mk(rmwOp(r[3:1]), occ_pkg::MODE_ACCUM, occ_pkg::CYC_IMPLIED, 1'b0);
          end
          4'h8: d = mk(occ_pkg::OP_TXA, occ_pkg::MODE_IMPLIED, occ_pkg::CYC_IMPLIED, 1'b0);
          4'h9: d = mk(occ_pkg::OP_TXS, occ_pkg::MODE_IMPLIED, occ_pkg::CYC_IMPLIED, 1'b0);
          4'hA: d = mk(occ_pkg::OP_TAX, occ_pkg::MODE_IMPLIED, occ_pkg::CYC_IMPLIED, 1'b0);
          4'hB: d = mk(occ_pkg::OP_TSX, occ_pkg::MODE_IMPLIED, occ_pkg::CYC_IMPLIED, 1'b0);
          4'hC: d = mk(occ_pkg::OP_DEX, occ_pkg::MODE_IMPLIED, occ_pkg::CYC_IMPLIED, 1'b0);
          4'hE: d = mk(occ_pkg::OP_IDLE, occ_pkg::MODE_IMPLIED, occ_pkg::CYC_IMPLIED, 1'b0);
          default: ;
        endcase
      end
      4'hC: begin
        case (r)
          4'h2: d = mk(occ_pkg::OP_TEST, occ_pkg::MODE_ABS, occ_pkg::CYC_ABS, 1'b0);
          4'h4: d = mk(occ_pkg::OP_JUMP, occ_pkg::MODE_ABS, occ_pkg::CYC_JUMP_ABS, 1'b0);
          4'h6: d = mk(occ_pkg::OP_JUMP, occ_pkg::MODE_INDIRECT, occ_pkg::CYC_JUMP_IND, 1'b0);
          4'h8: d = mk(occ_pkg::OP_STY, occ_pkg::MODE_ABS, occ_pkg::CYC_ABS, 1'b0);
          4'hA: d = mk(occ_pkg::OP_LDY, occ_pkg::MODE_ABS, occ_pkg::CYC_ABS, 1'b0);
          4'hB: d = mk(occ_pkg::OP_LDY, occ_pkg::MODE_ABS_X, occ_pkg::CYC_ABS_IDX, 1'b1);
          4'hC: d = mk(occ_pkg::OP_CPY, occ_pkg::MODE_ABS, occ_pkg::CYC_ABS, 1'b0);
          4'hE: d = mk(occ_pkg::OP_CPX, occ_pkg::MODE_ABS, occ_pkg::CYC_ABS, 1'b0);
          default: ;
        endcase
      end
      4'hD: begin
        if (r[0] && st) begin
          d = mk(occ_pkg::OP_STORE_A, occ_pkg::MODE_ABS_X, occ_pkg::CYC_STORE_ABSIDX, 1'b0);
        end else if (r[0]) begin
          d = mk(aluOp(r[3:1]), occ_pkg::MODE_ABS_X, occ_pkg::CYC_ABS_IDX, 1'b1);
        end else begin
          d = mk(aluOp(r[3:1]), occ_pkg::MODE_ABS, occ_pkg::CYC_ABS, 1'b0);
        end
      end
      4'hE: begin
        if (!r[0] && xy) begin
          d = mk(rmwOp(r[3:1]), occ_pkg::MODE_ABS, occ_pkg::CYC_ABS, 1'b0);
        end else if (!r[0]) begin
          d = mk(rmwOp(r[3:1]), occ_pkg::MODE_ABS, occ_pkg::CYC_RMW_ABS, 1'b0);
        end else if (r == 4'hB) begin
          d = mk(occ_pkg::OP_LOAD_X, occ_pkg::MODE_ABS_Y, occ_pkg::CYC_ABS_IDX, 1'b1);
        end else if (r != 4'h9) begin
          d = mk(rmwOp(r[3:1]), occ_pkg::MODE_ABS_X, occ_pkg::CYC_RMW_ABS_IDX, 1'b0);
        end
      end
      4'hF: begin
        d = mk(r[3] ? occ_pkg::OP_BIT_ONE_BR : occ_pkg::OP_BIT_CLR_BR, occ_pkg::MODE_ZERO_PAGE,
               occ_pkg::CYC_BIT_BRANCH, 1'b0);
        // Zero-page operand plus relative offset
        d.len      = occ_pkg::LEN_THREE;
        d.isBranch = 1'b1;
        d.bitSel   = r[2:0];
      end
      default: ;
    endcase
    return d;
  endfunction

  // Branch outcome from flags or from the zero-page byte
  function automatic logic takenOf(occ_pkg::occ_dec_t d, occ_pkg::occ_res_t s);
    logic f;
    logic t;
    case (d.bitSel[2:1])
      2'd0:    f = s.flagN;
      2'd1:    f = s.flagV;
      2'd2:    f = s.flagC;
      default: f = s.flagZ;
    endcase
    case (d.op)
      occ_pkg::OP_BRANCH:     t = (f == d.bitSel[0]);
      occ_pkg::OP_BIT_CLR_BR: t = !s.zeroPageByte[d.bitSel];
      occ_pkg::OP_BIT_ONE_BR: t = s.zeroPageByte[d.bitSel];
      default:                t = 1'b0;
    endcase
    return t;
  endfunction

  assign newDec   = decode(opByte);
  assign newTaken = takenOf(state_q.dec, resInfo);

  occ_cycle_adder uAdd (
    .dec       (state_q.dec),
    .pageCross (resInfo.pageCross),
    .farPage   (resInfo.farPage),
    .taken     (newTaken),
    .total     (sum)
  );

  always_comb begin
    state_d = state_q;
    case (state_q.fsm)
      occ_pkg::ST_FETCH: begin
        if (opValid) begin
          state_d.dec   = newDec;
          state_d.taken = 1'b0;
          state_d.total = {1'b0, newDec.cycles};
          // Nothing left to learn at run time: report at once
          if (newDec.isBranch || newDec.pagePenalty) begin
            state_d.fsm = occ_pkg::ST_RESOLVE;
          end else begin
            state_d.fsm = occ_pkg::ST_DONE;
          end
        end
      end
      occ_pkg::ST_RESOLVE: begin
        if (resValid) begin
          state_d.taken = newTaken;
          state_d.total = sum;
          state_d.fsm   = occ_pkg::ST_DONE;
        end
      end
      occ_pkg::ST_DONE: begin
        state_d.fsm = occ_pkg::ST_FETCH;
      end
      default: begin
        state_d.fsm = occ_pkg::ST_FETCH;
      end
    endcase
  end

  // Reset parks the machine in fetch with an undefined-slot decode
  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      state_q.fsm             <= occ_pkg::ST_FETCH;
      state_q.dec.op          <= occ_pkg::OP_UNDEF;
      state_q.dec.mode        <= occ_pkg::MODE_IMPLIED;
      state_q.dec.len         <= occ_pkg::LEN_ONE;
      state_q.dec.cycles      <= occ_pkg::CYC_IMPLIED;
      state_q.dec.pagePenalty <= 1'b0;
      state_q.dec.isBranch    <= 1'b0;
      state_q.dec.bitSel      <= 3'd0;
      state_q.taken           <= 1'b0;
      state_q.total           <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign opReady    = (state_q.fsm == occ_pkg::ST_FETCH);
  assign resReady   = (state_q.fsm == occ_pkg::ST_RESOLVE);
  assign decValid   = (state_q.fsm != occ_pkg::ST_FETCH);
  assign doneValid  = (state_q.fsm == occ_pkg::ST_DONE);
  assign decInfo    = state_q.dec;
  assign doneTaken  = state_q.taken;
  assign doneCycles = state_q.total;

endmodule

// >>> hdl/occ_pkg.sv
package occ_pkg;

  localparam int CYC_W = 4;
  typedef logic [2:0]       occ_base_t;
  typedef logic [CYC_W-1:0] occ_cyc_t;
  typedef logic [1:0]       occ_len_t;

  localparam occ_len_t LEN_ONE   = 2'd1;
  localparam occ_len_t LEN_TWO   = 2'd2;
  localparam occ_len_t LEN_THREE = 2'd3;

  localparam occ_base_t CYC_IMPLIED      = 3'd2;
  localparam occ_base_t CYC_BREAK        = 3'd7;
  localparam occ_base_t CYC_CALL         = 3'd6;
  localparam occ_base_t CYC_RETURN       = 3'd6;
  localparam occ_base_t CYC_JUMP_ABS     = 3'd3;
  localparam occ_base_t CYC_JUMP_IND     = 3'd5;
  localparam occ_base_t CYC_PUSH         = 3'd3;
  localparam occ_base_t CYC_PULL         = 3'd4;
  localparam occ_base_t CYC_BIT_BRANCH   = 3'd5;
  localparam occ_base_t CYC_BIT_RMW      = 3'd5;
  localparam occ_base_t CYC_REL          = 3'd2;
  localparam occ_base_t CYC_IMM          = 3'd2;
  localparam occ_base_t CYC_ZERO         = 3'd3;
  localparam occ_base_t CYC_ZERO_IDX     = 3'd4;
  localparam occ_base_t CYC_ABS          = 3'd4;
  localparam occ_base_t CYC_ABS_IDX      = 3'd4;
  localparam occ_base_t CYC_IND_X        = 3'd6;
  localparam occ_base_t CYC_IND_Y        = 3'd5;
  localparam occ_base_t CYC_STORE_IND_Y  = 3'd6;
  localparam occ_base_t CYC_STORE_ABSIDX = 3'd5;
  localparam occ_base_t CYC_RMW_ZERO     = 3'd5;
  localparam occ_base_t CYC_RMW_ZERO_IDX = 3'd6;
  localparam occ_base_t CYC_RMW_ABS      = 3'd6;
  localparam occ_base_t CYC_RMW_ABS_IDX  = 3'd7;
  localparam occ_cyc_t  CYC_PAGE_EXTRA   = 4'h1;
  localparam occ_cyc_t  CYC_BRANCH_NEAR  = 4'h1;
  localparam occ_cyc_t  CYC_BRANCH_FAR   = 4'h2;

  typedef enum logic [5:0] {
    OP_OR = 6'b000000, OP_AND = 6'b000001, OP_XOR = 6'b000010, OP_ADD = 6'b000011,
    OP_SUB = 6'b000100, OP_CMP = 6'b000101, OP_CPX = 6'b000110, OP_CPY = 6'b000111,
    OP_LDA = 6'b001000, OP_LOAD_X = 6'b001001, OP_LDY = 6'b001010, OP_STORE_A = 6'b001011,
    OP_STORE_X = 6'b001100, OP_STY = 6'b001101, OP_TEST = 6'b001110, OP_SHL = 6'b001111,
    OP_SHR = 6'b010000, OP_ROL = 6'b010001, OP_ROR = 6'b010010, OP_INC = 6'b010011,
    OP_DEC = 6'b010100, OP_INX = 6'b010101, OP_INY = 6'b010110, OP_DEX = 6'b010111,
    OP_DEY = 6'b011000, OP_TAX = 6'b011001, OP_TAY = 6'b011010, OP_TXA = 6'b011011,
    OP_TYA = 6'b011100, OP_TSX = 6'b011101, OP_TXS = 6'b011110, OP_CLC = 6'b011111,
    OP_SEC = 6'b100000, OP_CLI = 6'b100001, OP_SEI = 6'b100010, OP_CLV = 6'b100011,
    OP_CLD = 6'b100100, OP_SED = 6'b100101, OP_BRANCH = 6'b100110, OP_BREAK = 6'b100111,
    OP_CALL = 6'b101000, OP_IRET = 6'b101001, OP_RETURN = 6'b101010, OP_JUMP = 6'b101011,
    OP_PUSH_S = 6'b101100, OP_PULL_S = 6'b101101, OP_PUSH_A = 6'b101110,
    OP_PULL_A = 6'b101111, OP_IDLE = 6'b110000, OP_CLR_BIT = 6'b110001,
    OP_SET_BIT = 6'b110010, OP_BIT_CLR_BR = 6'b110011, OP_BIT_ONE_BR = 6'b110100,
    OP_UNDEF = 6'b110101
  } occ_op_t;

  typedef enum logic [3:0] {
    MODE_IMPLIED = 4'b0000, MODE_ACCUM = 4'b0001, MODE_IMM = 4'b0010,
    MODE_ZERO_PAGE = 4'b0011, MODE_ZERO_X = 4'b0100, MODE_ZERO_Y = 4'b0101,
    MODE_ABS = 4'b0110, MODE_ABS_X = 4'b0111, MODE_ABS_Y = 4'b1000,
    MODE_IND_X = 4'b1001, MODE_IND_Y = 4'b1010, MODE_REL = 4'b1011,
    MODE_INDIRECT = 4'b1100
  } occ_mode_t;

  typedef enum logic [1:0] {
    ST_FETCH = 2'b00, ST_RESOLVE = 2'b01, ST_DONE = 2'b10
  } occ_fsm_t;

  typedef struct packed {
    occ_op_t   op;
    occ_mode_t mode;
    occ_len_t  len;
    occ_base_t cycles;
    logic      pagePenalty;
    logic      isBranch;
    logic [2:0] bitSel;
  } occ_dec_t;

  typedef struct packed {
    logic       pageCross;
    logic       farPage;
    logic       flagN;
    logic       flagV;
    logic       flagC;
    logic       flagZ;
    logic [7:0] zeroPageByte;
  } occ_res_t;

  typedef struct packed {
    occ_fsm_t fsm;
    occ_dec_t dec;
    logic     taken;
    occ_cyc_t total;
  } occ_state_t;

endpackage

// >>> hdl/occ_reset_sync.sv
`timescale 1ns/100ps
module occ_reset_sync (
  // Clock and raw reset
  input  wire logic clk_sys,
  input  wire logic rst_n,
  // Released copy
  output logic      rstSync_n
);
  logic [1:0] sync_q;

  // Assert at once, release after two edges
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_q <= 2'b00;
    end else begin
      sync_q <= {sync_q[0], 1'b1};
    end
  end

  assign rstSync_n = sync_q[1];
endmodule

// >>> hdl/occ_cycle_adder.sv
`timescale 1ns/100ps
module occ_cycle_adder (
  // Decoded instruction
  input  wire occ_pkg::occ_dec_t dec,
  // Run-time facts
  input  wire logic              pageCross,
  input  wire logic              farPage,
  input  wire logic              taken,
  // Total machine cycles
  output occ_pkg::occ_cyc_t      total
);
  occ_pkg::occ_cyc_t extra;

  always_comb begin
    extra = '0;
    if (dec.isBranch) begin
      if (taken) begin
        extra = farPage ? occ_pkg::CYC_BRANCH_FAR : occ_pkg::CYC_BRANCH_NEAR;
      end
    end else if (dec.pagePenalty && pageCross) begin
      extra = occ_pkg::CYC_PAGE_EXTRA;
    end
    total = {1'b0, dec.cycles} + extra;
  end
endmodule

// >>> testbench/occ_seq_model.sv
`timescale 1ns/100ps
module occ_seq_model (
  // Clock and handshake
  input  wire logic              clk_sys,
  input  wire logic              resReady,
  output logic                   resValid,
  // Facts to offer, answer delay
  input  wire occ_pkg::occ_res_t cfg,
  input  wire logic [1:0]        dly,
  output occ_pkg::occ_res_t      resInfo
);
  logic [1:0] n;
  initial begin
    resValid = 1'b0;
    resInfo = '0;
    n = 2'h0;
  end
  // Released facts go inverted so stale values never look valid
  always @(posedge clk_sys) begin
    if (!resReady || resValid) begin
      resValid <= 1'b0;
      n <= 2'h0;
      resInfo <= ~cfg;
    end else if (n == dly) begin
      resValid <= 1'b1;
      resInfo <= cfg;
    end else n <= n + 2'h1;
  end
endmodule

// >>> testbench/occ_chk.sv
`timescale 1ns/100ps
module occ_chk (
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              rst_n,
  // Handshakes and results
  input wire logic              opValid,
  input wire logic              opReady,
  input wire logic [7:0]        opByte,
  input wire occ_pkg::occ_dec_t decInfo,
  input wire logic              resValid,
  input wire logic              resReady,
  input wire occ_pkg::occ_res_t resInfo,
  input wire logic              doneValid,
  input wire logic              doneTaken,
  input wire occ_pkg::occ_cyc_t doneCycles
);
  logic [7:0]        opQ;
  occ_pkg::occ_res_t rsQ;
  logic [3:0]        flg;
  assign flg = {rsQ.flagZ, rsQ.flagC, rsQ.flagV, rsQ.flagN};
  always_ff @(posedge clk_sys) begin
    if (opValid && opReady) opQ <= opByte;
    if (resValid && resReady) rsQ <= resInfo;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence s_take; opValid && opReady; endsequence
  sequence s_res; resValid && resReady; endsequence
  chk_break_seven: assert property (
    s_take ##0 opByte == 8'h00 |=> doneValid && doneCycles == 4'h7 && decInfo.len == 2'h1)
    else $error("break decode wrong");
  chk_bit_branch: assert property (
    s_take ##0 opByte[3:0] == 4'hF |=> decInfo.bitSel == opQ[6:4] && decInfo.len == 2'h3
    && decInfo.op == (opQ[7] ? occ_pkg::OP_BIT_ONE_BR : occ_pkg::OP_BIT_CLR_BR))
    else $error("bit branch decode wrong");
  chk_rmw_bit: assert property (
    s_take ##0 opByte[3:0] == 4'h7 |=> doneCycles == 4'h5 && decInfo.bitSel == opQ[6:4]
    && decInfo.op == (opQ[7] ? occ_pkg::OP_SET_BIT : occ_pkg::OP_CLR_BIT))
    else $error("bit set or clear decode wrong");
  chk_page_extra: assert property (
    s_res ##0 !decInfo.isBranch |=> doneValid && doneCycles == decInfo.cycles + rsQ.pageCross)
    else $error("page extra wrong");
  chk_branch_add: assert property (
    s_res ##0 decInfo.isBranch |=> doneCycles == decInfo.cycles
    + (doneTaken ? (rsQ.farPage ? 4'h2 : 4'h1) : 4'h0))
    else $error("branch penalty wrong");
  chk_flag_taken: assert property (
    s_res ##0 opQ[3:0] == 4'h0 |=> doneTaken == (flg[opQ[7:6]] == opQ[5]))
    else $error("flag branch outcome wrong");
  chk_bit_taken: assert property (
    s_res ##0 opQ[3:0] == 4'hF |=> doneTaken == (rsQ.zeroPageByte[opQ[6:4]] == opQ[7]))
    else $error("bit branch outcome wrong");
  chk_fast_done: assert property (
    s_take ##1 !decInfo.isBranch && !decInfo.pagePenalty
    |-> doneValid && doneCycles == decInfo.cycles && !doneTaken)
    else $error("direct completion wrong");
endmodule
bind occ_opcode_cycle_decoder occ_chk CHK (.clk_sys, .rst_n, .opValid, .opReady, .opByte,
  .decInfo, .resValid, .resReady, .resInfo, .doneValid, .doneTaken, .doneCycles);

// >>> testbench/opcode_cycle_decoder_tb.sv
`timescale 1ns/100ps
module opcode_cycle_decoder_tb;
  logic              clk_sys = 1'b0;
  logic              rst_n = 1'b0;
  logic              opValid = 1'b0;
  logic [7:0]        opByte = 8'h00;
  logic [1:0]        dly = 2'h0;
  occ_pkg::occ_res_t cfg = '0;
  occ_pkg::occ_res_t resInfo;
  occ_pkg::occ_dec_t decInfo;
  occ_pkg::occ_cyc_t doneCycles;
  logic              opReady, decValid, resValid, resReady, doneValid, doneTaken;
  int                err_count = 0;
  int                checked = 0;
  int                cyc = 0;
  always #5 clk_sys = ~clk_sys;
  occ_opcode_cycle_decoder DUT (.clk_sys, .rst_n, .opValid, .opReady, .opByte, .decValid,
    .decInfo, .resValid, .resReady, .resInfo, .doneValid, .doneTaken, .doneCycles);
  occ_seq_model SEQ (.clk_sys, .resReady, .resValid, .cfg, .dly, .resInfo);
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: flag got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    $display("Compares %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One opcode; run-time facts come from the sequencer model
  task automatic run(input logic [7:0] op, input logic [1:0] eLen, input logic [3:0] eCyc,
                     input logic eTk);
    int n = 0;
    opByte <= op;
    opValid <= 1'b1;
    @(posedge clk_sys);
    opValid <= 1'b0;
    opByte <= ~op;
    @(negedge clk_sys);
    cmp_bit(decValid, 1'b1);
    cmp_bit(opReady, 1'b0);
    while (doneValid !== 1'b1 && n++ < 20) @(negedge clk_sys);
    cmp_bit(doneValid, 1'b1);
    cmp_bit(resReady, 1'b0);
    cmp(doneCycles, eCyc);
    cmp_bit(doneTaken, eTk);
    cmp(decInfo.len, eLen);
    @(posedge clk_sys);
  endtask
  // Entries: opcode, length, cycles; page cross offered to catch stray extras
  task automatic t_table;
    logic [15:0] tbl [$] = {16'h0017,
      16'h2036, 16'h4016, 16'h6016, 16'h4C33, 16'h6C35,
      16'h0813, 16'h4813, 16'h2814, 16'h6814, 16'h9126, 16'h9935, 16'h9D35,
      16'h0625, 16'h1626, 16'h0E36, 16'h1E37, 16'hEA12, 16'h1812, 16'h0A12,
      16'hA922, 16'hA523, 16'hB524, 16'hAD34, 16'hA126, 16'hB624, 16'h9624,
      16'h0212, 16'hFC12};
    cfg = '0;
    cfg.pageCross = 1'b1;
    foreach (tbl[i]) run(tbl[i][15:8], tbl[i][5:4], tbl[i][3:0], 1'b0);
    for (int r = 0; r < 16; r++) run({r[3:0], 4'h7}, 2'h2, 4'h5, 1'b0);
  endtask
  task automatic t_page;
    for (int p = 0; p < 2; p++) begin
      cfg.pageCross = p[0];
      dly = 2'(p * 3);
      run(8'hB9, 2'h3, 4'(4 + p), 1'b0);
      run(8'hB1, 2'h2, 4'(5 + p), 1'b0);
    end
  endtask
  // Only the selected flag carries the tested value
  task automatic t_flagbr;
    logic [3:0] fl;
    logic       tk;
    for (int r = 1; r < 16; r += 2) for (int v = 0; v < 4; v++) begin
      fl = 4'b1000 >> r[3:2];
      {cfg.flagN, cfg.flagV, cfg.flagC, cfg.flagZ} = v[0] ? fl : ~fl;
      cfg.farPage = v[1];
      dly = r[2:1];
      tk = v[0] == r[1];
      run({r[3:0], 4'h0}, 2'h2, 4'(2 + tk * (1 + v[1])), tk);
    end
  endtask
  task automatic t_bitbr;
    logic tk;
    for (int r = 0; r < 16; r++) begin
      cfg.zeroPageByte = r[0] ? 8'h01 << r[2:0] : ~(8'h01 << r[2:0]);
      cfg.farPage = r[1];
      dly = r[1:0];
      tk = r[0] == r[3];
      run({r[3:0], 4'hF}, 2'h3, 4'(5 + tk * (1 + r[1])), tk);
    end
  endtask
  // Mid-run reset while a branch waits in resolve
  task automatic t_reset;
    opByte <= 8'hF0;
    opValid <= 1'b1;
    @(posedge clk_sys);
    opValid <= 1'b0;
    rst_n <= 1'b0;
    @(negedge clk_sys);
    cmp_bit(opReady, 1'b1);
    cmp_bit(decValid, 1'b0);
    cmp(doneCycles, 8'h00);
    cmp(decInfo.len, 8'h01);
    @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      stop_test;
    end
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    t_table;
    t_page;
    t_reset;
    t_flagbr;
    t_bitbr;
    stop_test;
  end
endmodule
